// ===== shared/cbdiag_pkg.sv
/*
 * package for the bus error diagnostic block: register offsets, field
 * positions, reset values and the bus answer state encoding.
 * assumes the protocol engine reports each error as a one-cycle pulse.
 */
package cbdiag_pkg;
	// ---------------------------------------------------------------
	// register map (word addresses, avalon word addressing)
	// ---------------------------------------------------------------
	localparam int unsigned addr_w = 2;
	localparam logic [1:0] error_counters_off = 2'h0;
	localparam logic [1:0] error_kind_flags_off = 2'h1;
	localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

	// ---------------------------------------------------------------
	// error_counters fields
	// ---------------------------------------------------------------
	localparam int unsigned nom_rx_cnt_lsb = 0;
	localparam int unsigned nom_tx_cnt_lsb = 8;
	localparam int unsigned dat_rx_cnt_lsb = 16;
	localparam int unsigned dat_tx_cnt_lsb = 24;
	localparam logic [7:0] err_cnt_reset = 8'h00;

	// ---------------------------------------------------------------
	// error_kind_flags fields
	// ---------------------------------------------------------------
	localparam int unsigned ef_msg_cnt_lsb = 0;
	localparam logic [15:0] ef_msg_cnt_reset = 16'h0000;
	localparam int unsigned flag_lsb = 16;
	localparam int unsigned nom_dom_bit = 16;
	localparam int unsigned nom_rec_bit = 17;
	localparam int unsigned ack_bit = 18;
	localparam int unsigned nom_form_bit = 19;
	localparam int unsigned nom_stuff_bit = 20;
	localparam int unsigned nom_crc_bit = 21;
	localparam int unsigned rsvd_a_bit = 22;
	localparam int unsigned bus_off_bit = 23;
	localparam int unsigned dat_dom_bit = 24;
	localparam int unsigned dat_rec_bit = 25;
	localparam int unsigned rsvd_b_bit = 26;
	localparam int unsigned dat_form_bit = 27;
	localparam int unsigned dat_stuff_bit = 28;
	localparam int unsigned dat_crc_bit = 29;
	localparam int unsigned esi_bit = 30;
	localparam int unsigned dlc_mm_bit = 31;
	localparam logic [15:0] flags_reset = 16'h0000;
	// flag bits that may ever be set (reserved 22 and 26 excluded)
	localparam logic [15:0] flags_valid = 16'hfbbf;

	// ---------------------------------------------------------------
	// bus answer states
	// ---------------------------------------------------------------
	typedef enum logic [0:0] {
		cbdiag_idle,
		cbdiag_done
	} cbdiag_bus_st_t;
endpackage : cbdiag_pkg

// ===== src/cbdiag_err_cnt.sv
/*
 * one width-bit wrapping error counter, 8 bits by default.
 * assumes inc is a one-cycle pulse per detected error.
 */
module cbdiag_err_cnt #(
	parameter int unsigned width = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic inc,
	output logic [width-1:0] count
);
	initial begin
		if (width < 1 || width > 32) begin
			$error("cbdiag_err_cnt: width out of range");
		end
	end

	typedef struct packed {
		logic [width-1:0] cnt;
	} cbdiag_cnt_state_t;

	cbdiag_cnt_state_t state_ff;
	cbdiag_cnt_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		// wraps from all ones to zero
		if (inc) begin
			nxt_state.cnt = state_ff.cnt + width'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff.cnt <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign count = state_ff.cnt;
endmodule : cbdiag_err_cnt

// ===== src/cbdiag_flags.sv
/*
 * sticky error-kind flags and error-free message counter, cleared on read.
 * assumes clr is a one-cycle pulse at the accepted read of the register.
 */
module cbdiag_flags (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] set_flags,
	input wire logic ok_msg,
	input wire logic clr,
	output logic [31:0] value
);
	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] ef_cnt;
	} cbdiag_flag_state_t;

	cbdiag_flag_state_t state_ff;
	cbdiag_flag_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (clr) begin
			// an event in the clearing cycle survives the clear
			nxt_state.flags = set_flags & cbdiag_pkg::flags_valid;
			nxt_state.ef_cnt = ok_msg ? 16'h0001 : cbdiag_pkg::ef_msg_cnt_reset;
		end else begin
			nxt_state.flags = state_ff.flags | (set_flags & cbdiag_pkg::flags_valid);
			nxt_state.ef_cnt = state_ff.ef_cnt + {15'h0000, ok_msg};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff.flags <= cbdiag_pkg::flags_reset;
			state_ff.ef_cnt <= cbdiag_pkg::ef_msg_cnt_reset;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign value = {state_ff.flags, state_ff.ef_cnt};
endmodule : cbdiag_flags

// ===== src/cbdiag_top.sv
/*
 * bus error diagnostics for one can fd port: four error counters and
 * a clear-on-read register of error kinds, behind an avalon-mm slave.
 * assumes the protocol engine gives one-cycle pulses on the same clock.
 */
// Our own choices: the register addresses and the Avalon-MM register port.
// Operation
// RL1: nominal receive error count in byte 0
// RL2: nominal transmit error count in byte 1
// RL3: data phase receive error count in byte 2
// RL4: data phase transmit error count in byte 3
// RL5: each counter adds one per error
// RL6: error kinds held as sticky flags
// RL7: reading flags register returns then clears it
// RL8: error-free message count in low half
// RL9: bit 16 nominal dominant bit error
// RL10: bit 17 nominal recessive bit error
// RL11: bit 18 missing acknowledge
// RL12: bit 19 nominal form error
// RL13: bit 20 nominal stuffing error
// RL14: bit 21 nominal checksum error
// RL15: bits 22 and 26 read zero
// RL16: bit 23 bus-off then recovered
// RL17: bits 24,25,27,28,29 data phase errors
// RL18: bit 30 received esi set
// RL19: bit 31 length code mismatch
// RL20: counters wrap, reading them changes nothing
// RL21: event during clearing read is kept
module cbdiag_top #(
	parameter int unsigned cnt_width = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic nominal_rx_error,
	input wire logic nominal_tx_error,
	input wire logic data_phase_rx_error,
	input wire logic data_phase_tx_error,
	input wire logic error_free_message,
	input wire logic nominal_dominant_bit_error,
	input wire logic nominal_recessive_bit_error,
	input wire logic missing_acknowledge_error,
	input wire logic nominal_form_error,
	input wire logic nominal_stuffing_error,
	input wire logic nominal_checksum_error,
	input wire logic bus_off_recovered,
	input wire logic data_phase_dominant_bit_error,
	input wire logic data_phase_recessive_bit_error,
	input wire logic data_phase_form_error,
	input wire logic data_phase_stuffing_error,
	input wire logic data_phase_checksum_error,
	input wire logic esi_received,
	input wire logic length_code_mismatch
);
	initial begin
		if (cnt_width != 8) begin
			$error("cbdiag_top: counter width must be 8 to fit its byte");
		end
	end

	// ---------------------------------------------------------------
	// error counters
	// ---------------------------------------------------------------
	logic [7:0] nominal_rx_error_count;
	logic [7:0] nominal_tx_error_count;
	logic [7:0] data_phase_rx_error_count;
	logic [7:0] data_phase_tx_error_count;

	cbdiag_err_cnt #(.width(cnt_width)) u_nom_rx ( // RL1 RL5 RL20
		.clock(clock),
		.rst_n(rst_n),
		.inc(nominal_rx_error),
		.count(nominal_rx_error_count)
	);
	cbdiag_err_cnt #(.width(cnt_width)) u_nom_tx ( // RL2 RL5 RL20
		.clock(clock),
		.rst_n(rst_n),
		.inc(nominal_tx_error),
		.count(nominal_tx_error_count)
	);
	cbdiag_err_cnt #(.width(cnt_width)) u_dat_rx ( // RL3 RL5 RL20
		.clock(clock),
		.rst_n(rst_n),
		.inc(data_phase_rx_error),
		.count(data_phase_rx_error_count)
	);
	cbdiag_err_cnt #(.width(cnt_width)) u_dat_tx ( // RL4 RL5 RL20
		.clock(clock),
		.rst_n(rst_n),
		.inc(data_phase_tx_error),
		.count(data_phase_tx_error_count)
	);

	logic [31:0] error_counters;
	assign error_counters = {data_phase_tx_error_count, data_phase_rx_error_count,
		nominal_tx_error_count, nominal_rx_error_count}; // RL1 RL2 RL3 RL4

	// ---------------------------------------------------------------
	// error kind flags
	// ---------------------------------------------------------------
	logic [15:0] set_flags;
	logic [31:0] error_kind_flags;
	logic rd_clear;

	always_comb begin
		set_flags = 16'h0000;
		set_flags[cbdiag_pkg::nom_dom_bit - cbdiag_pkg::flag_lsb] =
			nominal_dominant_bit_error; // RL9
		set_flags[cbdiag_pkg::nom_rec_bit - cbdiag_pkg::flag_lsb] =
			nominal_recessive_bit_error; // RL10
		set_flags[cbdiag_pkg::ack_bit - cbdiag_pkg::flag_lsb] =
			missing_acknowledge_error; // RL11
		set_flags[cbdiag_pkg::nom_form_bit - cbdiag_pkg::flag_lsb] =
			nominal_form_error; // RL12
		set_flags[cbdiag_pkg::nom_stuff_bit - cbdiag_pkg::flag_lsb] =
			nominal_stuffing_error; // RL13
		set_flags[cbdiag_pkg::nom_crc_bit - cbdiag_pkg::flag_lsb] =
			nominal_checksum_error; // RL14
		set_flags[cbdiag_pkg::bus_off_bit - cbdiag_pkg::flag_lsb] =
			bus_off_recovered; // RL16
		set_flags[cbdiag_pkg::dat_dom_bit - cbdiag_pkg::flag_lsb] =
			data_phase_dominant_bit_error; // RL17
		set_flags[cbdiag_pkg::dat_rec_bit - cbdiag_pkg::flag_lsb] =
			data_phase_recessive_bit_error; // RL17
		set_flags[cbdiag_pkg::dat_form_bit - cbdiag_pkg::flag_lsb] =
			data_phase_form_error; // RL17
		set_flags[cbdiag_pkg::dat_stuff_bit - cbdiag_pkg::flag_lsb] =
			data_phase_stuffing_error; // RL17
		set_flags[cbdiag_pkg::dat_crc_bit - cbdiag_pkg::flag_lsb] =
			data_phase_checksum_error; // RL17
		set_flags[cbdiag_pkg::esi_bit - cbdiag_pkg::flag_lsb] = esi_received; // RL18
		set_flags[cbdiag_pkg::dlc_mm_bit - cbdiag_pkg::flag_lsb] =
			length_code_mismatch; // RL19
	end

	cbdiag_flags u_flags ( // RL6 RL8 RL15 RL21
		.clock(clock),
		.rst_n(rst_n),
		.set_flags(set_flags),
		.ok_msg(error_free_message),
		.clr(rd_clear),
		.value(error_kind_flags)
	);

	// ---------------------------------------------------------------
	// avalon-mm slave
	// ---------------------------------------------------------------
	typedef struct packed {
		cbdiag_pkg::cbdiag_bus_st_t st;
		logic [31:0] rdata;
		logic waitreq;
	} cbdiag_bus_state_t;

	cbdiag_bus_state_t bus_ff;
	cbdiag_bus_state_t nxt_bus;

	function automatic logic [31:0] read_mux(input logic [1:0] addr,
			input logic [31:0] cnts, input logic [31:0] flags);
		logic [31:0] r;
		unique case (addr)
			cbdiag_pkg::error_counters_off: r = cnts;
			cbdiag_pkg::error_kind_flags_off: r = flags;
			default: r = cbdiag_pkg::unmapped_read_value;
		endcase
		return r;
	endfunction : read_mux

	// capture in idle, answer one cycle later, then release
	always_comb begin
		nxt_bus = bus_ff;
		unique case (bus_ff.st)
			cbdiag_pkg::cbdiag_idle: begin
				if (avs_read || avs_write) begin
					nxt_bus.st = cbdiag_pkg::cbdiag_done;
					nxt_bus.waitreq = 1'b0;
					nxt_bus.rdata = avs_read ?
						read_mux(avs_address, error_counters, error_kind_flags) :
						32'h0000_0000;
				end
			end
			cbdiag_pkg::cbdiag_done: begin
				nxt_bus.st = cbdiag_pkg::cbdiag_idle;
				nxt_bus.waitreq = 1'b1;
			end
		endcase
	end

	// clear at the sampling of the snapshot, so the returned value is complete
	assign rd_clear = (bus_ff.st == cbdiag_pkg::cbdiag_idle) && avs_read &&
		(avs_address == cbdiag_pkg::error_kind_flags_off); // RL7

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_ff.st <= cbdiag_pkg::cbdiag_idle;
			bus_ff.rdata <= 32'h0000_0000;
			bus_ff.waitreq <= 1'b1;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	assign avs_readdata = bus_ff.rdata;
	assign avs_waitrequest = bus_ff.waitreq;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_nom_rx_inc;
		@(posedge clock) disable iff (!rst_n)
		nominal_rx_error |=> nominal_rx_error_count == $past(nominal_rx_error_count) + 8'h01;
	endproperty
	a_nom_rx_inc: assert property (p_nom_rx_inc) else $error("nominal rx count not +1"); // RL1

	property p_nom_tx_inc;
		@(posedge clock) disable iff (!rst_n)
		nominal_tx_error |=> nominal_tx_error_count == $past(nominal_tx_error_count) + 8'h01;
	endproperty
	a_nom_tx_inc: assert property (p_nom_tx_inc) else $error("nominal tx count not +1"); // RL2

	property p_dat_rx_hold;
		@(posedge clock) disable iff (!rst_n)
		!data_phase_rx_error |=> $stable(data_phase_rx_error_count);
	endproperty
	a_dat_rx_hold: assert property (p_dat_rx_hold) else $error("data rx count moved"); // RL3

	property p_dat_tx_inc;
		@(posedge clock) disable iff (!rst_n)
		data_phase_tx_error |=> data_phase_tx_error_count == $past(data_phase_tx_error_count) + 8'h01;
	endproperty
	a_dat_tx_inc: assert property (p_dat_tx_inc) else $error("data tx count not +1"); // RL4

	property p_rsvd_zero;
		@(posedge clock) disable iff (!rst_n)
		error_kind_flags[cbdiag_pkg::rsvd_a_bit] == 1'b0 &&
			error_kind_flags[cbdiag_pkg::rsvd_b_bit] == 1'b0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved flag bit set"); // RL15

	property p_sticky;
		@(posedge clock) disable iff (!rst_n)
		(error_kind_flags[cbdiag_pkg::esi_bit] && !rd_clear) |=>
			error_kind_flags[cbdiag_pkg::esi_bit];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost without clear"); // RL6

	property p_read_clears;
		@(posedge clock) disable iff (!rst_n)
		(rd_clear && set_flags == 16'h0000 && !error_free_message) |=>
			error_kind_flags == 32'h0000_0000 ##1 avs_waitrequest;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // RL7

	property p_set_wins;
		@(posedge clock) disable iff (!rst_n)
		(rd_clear && missing_acknowledge_error) |=> error_kind_flags[cbdiag_pkg::ack_bit];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost at clear"); // RL21

	property p_read_answer;
		@(posedge clock) disable iff (!rst_n)
		(avs_read && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("bus answer timing"); // RL7

	property p_nom_tx_keep;
		@(posedge clock) disable iff (!rst_n)
		!nominal_tx_error |=> $stable(nominal_tx_error_count);
	endproperty
	a_nom_tx_keep: assert property (p_nom_tx_keep) else $error("nominal tx count moved"); // RL5

	property p_nom_rx_wrap;
		@(posedge clock) disable iff (!rst_n)
		nominal_rx_error && (&nominal_rx_error_count) |=> nominal_rx_error_count == 8'h00;
	endproperty
	a_nom_rx_wrap: assert property (p_nom_rx_wrap) else $error("nominal rx count no wrap"); // RL20

	property p_ef_inc;
		@(posedge clock) disable iff (!rst_n)
		error_free_message && !rd_clear |=>
			error_kind_flags[15:0] == $past(error_kind_flags[15:0]) + 16'h0001;
	endproperty
	a_ef_inc: assert property (p_ef_inc) else $error("error-free count not +1"); // RL8

	property p_dom_set;
		@(posedge clock) disable iff (!rst_n)
		nominal_dominant_bit_error |=> error_kind_flags[cbdiag_pkg::nom_dom_bit];
	endproperty
	a_dom_set: assert property (p_dom_set) else $error("dominant bit flag not set"); // RL9

	property p_rec_set;
		@(posedge clock) disable iff (!rst_n)
		nominal_recessive_bit_error |=> error_kind_flags[cbdiag_pkg::nom_rec_bit];
	endproperty
	a_rec_set: assert property (p_rec_set) else $error("recessive bit flag not set"); // RL10

	property p_form_set;
		@(posedge clock) disable iff (!rst_n)
		nominal_form_error |=> error_kind_flags[cbdiag_pkg::nom_form_bit];
	endproperty
	a_form_set: assert property (p_form_set) else $error("form flag not set"); // RL12

	property p_stuff_set;
		@(posedge clock) disable iff (!rst_n)
		nominal_stuffing_error |=> error_kind_flags[cbdiag_pkg::nom_stuff_bit];
	endproperty
	a_stuff_set: assert property (p_stuff_set) else $error("stuffing flag not set"); // RL13

	property p_crc_set;
		@(posedge clock) disable iff (!rst_n)
		nominal_checksum_error |=> error_kind_flags[cbdiag_pkg::nom_crc_bit];
	endproperty
	a_crc_set: assert property (p_crc_set) else $error("checksum flag not set"); // RL14

	property p_bus_off_set;
		@(posedge clock) disable iff (!rst_n)
		bus_off_recovered |=> error_kind_flags[cbdiag_pkg::bus_off_bit];
	endproperty
	a_bus_off_set: assert property (p_bus_off_set) else $error("bus-off flag not set"); // RL16

	property p_dat_crc_set;
		@(posedge clock) disable iff (!rst_n)
		data_phase_checksum_error |=> error_kind_flags[cbdiag_pkg::dat_crc_bit];
	endproperty
	a_dat_crc_set: assert property (p_dat_crc_set) else $error("data crc flag not set"); // RL17

	property p_esi_set;
		@(posedge clock) disable iff (!rst_n)
		esi_received |=> error_kind_flags[cbdiag_pkg::esi_bit];
	endproperty
	a_esi_set: assert property (p_esi_set) else $error("esi flag not set"); // RL18

	property p_dlc_set;
		@(posedge clock) disable iff (!rst_n)
		length_code_mismatch |=> error_kind_flags[cbdiag_pkg::dlc_mm_bit];
	endproperty
	a_dlc_set: assert property (p_dlc_set) else $error("length code flag not set"); // RL19

	c_flags_read: cover property (@(posedge clock) disable iff (!rst_n)
		rd_clear && error_kind_flags != 32'h0000_0000);
	c_wrap: cover property (@(posedge clock) disable iff (!rst_n)
		nominal_rx_error && nominal_rx_error_count == 8'hff);
	c_set_at_clear: cover property (@(posedge clock) disable iff (!rst_n)
		rd_clear && set_flags != 16'h0000);
	c_write: cover property (@(posedge clock) disable iff (!rst_n)
		avs_write && avs_waitrequest);
endmodule : cbdiag_top

// ===== verif/cbdiag_bus_model.sv
/*
 * far-side model: the protocol engine and the other bus nodes, seen as
 * error and message events. a command vector from the bench becomes, one
 * clock later, one event pulse per set bit and per cycle it is held.
 * assumes the bench drives cmd right after a rising edge.
 */
module cbdiag_bus_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [18:0] cmd,
	output logic [18:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	// registered, so a pulse never carries glitches
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ev <= 19'h00000;
		end else begin
			ev <= cmd;
		end
	end
endmodule : cbdiag_bus_model

// ===== verif/tb_top.sv
/*
 * self-checking bench for the bus error diagnostic block: avalon reads
 * and writes, event traffic from the far-side model, a reference model.
 * assumes the one-cycle wait of the slave and pulse events per cycle.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, rd, wr, wait_req;
	logic [1:0] addr;
	logic [3:0] be;
	logic [31:0] wdata, rdata, snap, d, e_cnt;
	logic [18:0] cmd, ev;
	logic [15:0] e_flg, e_ef;
	int n_errors, tests_run;
	integer seed;

	cbdiag_bus_model model_u (.clock(clock), .rst_n(rst_n), .cmd(cmd), .ev(ev));
	cbdiag_top dut_u (
		.clock(clock), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wait_req),
		.nominal_rx_error(ev[0]), .nominal_tx_error(ev[1]), .data_phase_rx_error(ev[2]),
		.data_phase_tx_error(ev[3]), .error_free_message(ev[4]),
		.nominal_dominant_bit_error(ev[5]), .nominal_recessive_bit_error(ev[6]),
		.missing_acknowledge_error(ev[7]), .nominal_form_error(ev[8]),
		.nominal_stuffing_error(ev[9]), .nominal_checksum_error(ev[10]),
		.bus_off_recovered(ev[11]), .data_phase_dominant_bit_error(ev[12]),
		.data_phase_recessive_bit_error(ev[13]), .data_phase_form_error(ev[14]),
		.data_phase_stuffing_error(ev[15]), .data_phase_checksum_error(ev[16]),
		.esi_received(ev[17]), .length_code_mismatch(ev[18])
	);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// reference model
	// ---------------------------------------------------------------
	function automatic logic [31:0] cnt_next(input logic [31:0] c, input logic [3:0] inc);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r[8*i +: 8] = r[8*i +: 8] + {7'h00, inc[i]};
		end
		return r;
	endfunction : cnt_next

	// reserved 22 and 26 never set
	function automatic logic [15:0] flag_map(input logic [13:0] f);
		return {f[13:9], 1'b0, f[8:6], 1'b0, f[5:0]};
	endfunction : flag_map

	always @(posedge clock) begin
		if (!rst_n) begin
			e_cnt = 32'h0000_0000;
			e_flg = 16'h0000;
			e_ef = 16'h0000;
		end else begin
			if (rd && wait_req === 1'b1) begin
				if (addr == cbdiag_pkg::error_counters_off) begin
					snap = e_cnt;
				end else if (addr == cbdiag_pkg::error_kind_flags_off) begin
					snap = {e_flg, e_ef};
					e_flg = 16'h0000;
					e_ef = 16'h0000;
				end else begin
					snap = cbdiag_pkg::unmapped_read_value;
				end
			end
			e_cnt = cnt_next(e_cnt, ev[3:0]);
			e_ef = e_ef + {15'h0000, ev[4]};
			e_flg = e_flg | flag_map(ev[18:5]);
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: read %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [1:0] a, output logic [31:0] r);
		int n;
		@(posedge clock);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= $random(seed);
		be <= 4'($random(seed));
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wait_req !== 1'b0 && n < 100);
		if (n >= 100) begin
			n_errors++;
			results();
		end
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [1:0] a);
		bus(1'b0, a, d);
		check(d, snap);
	endtask : rd_chk

	task automatic pulse(input logic [18:0] v, input int n);
		@(posedge clock);
		cmd <= v;
		repeat (n) @(posedge clock);
		cmd <= 19'h00000;
	endtask : pulse

	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		results();
	end

	initial begin
		seed = 32'he9385ec5;
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		{rd, wr, addr, be, wdata, cmd} = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk(2'h0);
		rd_chk(2'h1);
		for (int i = 5; i < 19; i++) begin
			pulse(19'h00001 << i, 1);
			rd_chk(2'h1);
			rd_chk(2'h1);
		end
		pulse(19'h7ffff, 3);
		rd_chk(2'h1);
		check(d & 32'h0440_0000, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			pulse(19'h00001 << i, i + 1);
		end
		rd_chk(2'h0);
		pulse(19'h0000f, 260);
		rd_chk(2'h0);
		rd_chk(2'h0);
		pulse(19'h00010, 300);
		rd_chk(2'h1);
		fork
			pulse(19'h7fff0, 6);
			begin
				@(posedge clock);
				rd_chk(2'h1);
			end
		join
		rd_chk(2'h1);
		pulse(19'h7ffff, 2);
		bus(1'b1, 2'h1, d);
		bus(1'b1, 2'h0, d);
		rd_chk(2'h1);
		rd_chk(2'h0);
		rd_chk(2'h2);
		rd_chk(2'h3);
		repeat (400) begin
			fork
				pulse(19'($random(seed) & $random(seed) & $random(seed)), 1 + ($random(seed) & 3));
				if ($random(seed) & 1) begin
					rd_chk(2'($random(seed)));
				end else begin
					bus(1'b1, 2'($random(seed)), d);
				end
			join
		end
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		rd_chk(2'h0);
		rd_chk(2'h1);
		results();
	end
endmodule : tb_top
